// File: rtl/bpcm_breakpoint_control_match.sv
// four-slot hardware breakpoint control and match logic with apb registers
`include "bpcm_consts.svh"
module bpcm_breakpoint_control_match
   import bpcm_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        srst,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // execution core side
   input  wire logic        instrStart,
   input  wire logic [31:0] instrAddr,
   input  wire logic        dataValid,
   input  wire logic        dataWrite,
   input  wire logic [31:0] dataAddr,
   input  wire logic [1:0]  dataBytesMinus1,
   input  wire logic        dataDone,
   input  wire logic        taskSwitch,
   input  wire logic        handlerEntry,
   input  wire logic        dbgRegAccess,
   input  wire logic        protMode,
   input  wire logic [1:0]  privLevel,
   output logic             faultExc1,
   output logic             trapExc1,
   output logic             privViolation,
   output logic             exactWait
);
   logic [31:0] slotAddr [4];
   logic [31:0] next_slotAddr [4];
   logic [31:0] ctrlWord;
   logic [31:0] next_ctrlWord;
   logic [3:0]  hitFlags;
   logic [3:0]  next_hitFlags;
   logic        guardHit;
   logic        next_guardHit;
   logic        trapPend;
   logic        next_trapPend;
   logic [3:0]  instMatch;
   logic [3:0]  dataMatch;
   logic [3:0]  armed;
   logic        wrStb;
   logic        rdStb;
   logic        guardFault;
   logic        anyInstHit;
   logic        anyDataHit;
   logic        exactOn;
   logic [31:0] dataEnd;

   assign wrStb = psel && penable && pwrite;
   assign rdStb = psel && penable && !pwrite;
   assign pready = 1'b1;
   // dataEnd is the last byte of the access; carry past 4 GiB is dropped on purpose
   assign dataEnd = dataAddr + {30'h0000_0000, dataBytesMinus1};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_slot
         bpcm_size_e   sz;
         bpcm_access_e at;
         logic [31:0]  mask;
         logic [31:0]  lo;
         logic [31:0]  hi;
         logic         typeOk;
         assign sz = bpcm_size_e'(ctrlWord[`BPCM_CTRL_TYPE_LSB + 4*gi + 2 +: 2]);
         assign at = bpcm_access_e'(ctrlWord[`BPCM_CTRL_TYPE_LSB + 4*gi +: 2]);
         always_comb begin
            unique case (sz)
               BPCM_SZ_BYTE:  mask = 32'hffff_ffff;
               BPCM_SZ_WORD:  mask = 32'hffff_fffe;
               BPCM_SZ_DWORD: mask = 32'hffff_fffc;
               default:       mask = 32'hffff_ffff;
            endcase
         end
         assign lo = slotAddr[gi] & mask;
         assign hi = slotAddr[gi] | ~mask;
         // undefined codes give no match at all
         assign typeOk = (sz != BPCM_SZ_UNDEF) && (at != BPCM_AT_UNDEF);
         // exact start-byte compare only, so hits inside an instruction are ignored
         assign instMatch[gi] = typeOk && at == BPCM_AT_EXEC && instrStart
                                && instrAddr == lo && sz == BPCM_SZ_BYTE;
         assign dataMatch[gi] = typeOk && dataValid && at != BPCM_AT_EXEC
                                && (dataWrite || at == BPCM_AT_RDWR)
                                && dataAddr <= hi && dataEnd >= lo;
         assign armed[gi] = ctrlWord[2*gi] || ctrlWord[2*gi + 1];
      end
   endgenerate

   assign anyInstHit = |(instMatch & armed);
   assign anyDataHit = |(dataMatch & armed);
   assign guardFault = dbgRegAccess && ctrlWord[`BPCM_CTRL_GD_BIT];
   assign privViolation = dbgRegAccess && protMode && privLevel != 2'h0;
   assign exactOn = ctrlWord[`BPCM_CTRL_LE_BIT] || ctrlWord[`BPCM_CTRL_GE_BIT];
   // execute breakpoints fault before the instruction, so never delayed
   assign faultExc1 = anyInstHit || guardFault;
   // without exact mode the trap waits for the next instruction boundary
   assign trapExc1 = exactOn ? (trapPend && dataDone) : (trapPend && instrStart);
   assign exactWait = exactOn && dataValid;

   always_comb begin
      next_ctrlWord = ctrlWord;
      next_slotAddr = slotAddr;
      next_hitFlags = hitFlags;
      next_guardHit = guardHit;
      next_trapPend = trapPend;
      if (wrStb) begin
         unique case (paddr)
            `BPCM_ADDR_SLOT0:   next_slotAddr[0] = pwdata;
            `BPCM_ADDR_SLOT1:   next_slotAddr[1] = pwdata;
            `BPCM_ADDR_SLOT2:   next_slotAddr[2] = pwdata;
            `BPCM_ADDR_SLOT3:   next_slotAddr[3] = pwdata;
            `BPCM_ADDR_CONTROL: next_ctrlWord = pwdata;
            `BPCM_ADDR_STATUS: begin
               next_hitFlags = pwdata[3:0];
               next_guardHit = pwdata[`BPCM_STAT_GUARD_BIT];
            end
            default: ;
         endcase
      end
      if (taskSwitch) begin
         for (int i = 0; i < 4; i++) begin
            next_ctrlWord[2*i] = 1'b0;
         end
         next_ctrlWord[`BPCM_CTRL_LE_BIT] = 1'b0;
      end
      // hardware set wins over a software write in the same cycle
      if (anyInstHit) begin
         next_hitFlags = next_hitFlags | instMatch | dataMatch;
      end
      if (anyDataHit) begin
         next_hitFlags = next_hitFlags | instMatch | dataMatch;
         next_trapPend = 1'b1;
      end else if (trapExc1) begin
         next_trapPend = 1'b0;
      end
      if (guardFault) begin
         next_guardHit = 1'b1;
      end
      if (handlerEntry) begin
         next_ctrlWord[`BPCM_CTRL_GD_BIT] = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         ctrlWord <= `BPCM_CTRL_RESET;
         for (int i = 0; i < 4; i++) begin
            slotAddr[i] <= 32'h0000_0000;
         end
         hitFlags <= 4'h0;
         guardHit <= 1'b0;
         trapPend <= 1'b0;
      end else begin
         ctrlWord <= next_ctrlWord;
         slotAddr <= next_slotAddr;
         hitFlags <= next_hitFlags;
         guardHit <= next_guardHit;
         trapPend <= next_trapPend;
      end
   end

   logic [31:0] next_prdata;
   logic        next_pslverr;
   always_comb begin
      next_prdata = 32'h0000_0000;
      next_pslverr = 1'b0;
      unique case (paddr)
         `BPCM_ADDR_SLOT0:   next_prdata = slotAddr[0];
         `BPCM_ADDR_SLOT1:   next_prdata = slotAddr[1];
         `BPCM_ADDR_SLOT2:   next_prdata = slotAddr[2];
         `BPCM_ADDR_SLOT3:   next_prdata = slotAddr[3];
         `BPCM_ADDR_CONTROL: next_prdata = ctrlWord;
         `BPCM_ADDR_STATUS:
            next_prdata = {18'h0_0000, guardHit, 9'h000, hitFlags} & `BPCM_STAT_MASK;
         default:            next_pslverr = 1'b1;
      endcase
   end

   // read data is combinational from registers, so pready can stay high
   assign prdata = rdStb ? next_prdata : 32'h0000_0000;
   assign pslverr = psel && penable && next_pslverr;
endmodule

// File: rtl/bpcm_consts.svh
// offsets, field positions and reset values of the breakpoint control block
// How it works
// - two-bit size code: 1, 2 or 4 bytes
// - compare ignores low address bits per size
// - access type: execute, write, read/write
// - data access overlapping field wholly or partly matches
// - execute match only at instruction start byte
// - execute raises fault, data raises trap
// - armed when local or global arm set
// - task switch clears local arm bits, keeps global ones
// - debug register access only real mode or level 0
// - guard bit set makes any debug register access fault
// - guard bit cleared when handler is entered
// - exact bit set forces wait for operand transfer
// - task switch clears local exact, keeps global
// - execute breakpoints always reported exactly
// - all breakpoints disarmed after reset
// - four 32-bit linear address slots compared continuously
// - any armed hit sets all matching flags, cleared only by a status write or reset
`ifndef BPCM_CONSTS_SVH
`define BPCM_CONSTS_SVH
`define BPCM_ADDR_SLOT0     12'h000
`define BPCM_ADDR_SLOT1     12'h004
`define BPCM_ADDR_SLOT2     12'h008
`define BPCM_ADDR_SLOT3     12'h00c
`define BPCM_ADDR_STATUS    12'h018
`define BPCM_ADDR_CONTROL   12'h01c
`define BPCM_CTRL_RESET     32'h0000_0000
`define BPCM_CTRL_LE_BIT    8
`define BPCM_CTRL_GE_BIT    9
`define BPCM_CTRL_GD_BIT    13
`define BPCM_CTRL_TYPE_LSB  16
`define BPCM_STAT_GUARD_BIT 13
`define BPCM_STAT_MASK      32'h0000_200f
`define BPCM_SLOT_ERR_BIT   0
`endif

// File: rtl/bpcm_pkg.sv
// types shared by the breakpoint control block
package bpcm_pkg;
   typedef enum logic [1:0] {
      BPCM_SZ_BYTE  = 2'h0,
      BPCM_SZ_WORD  = 2'h1,
      BPCM_SZ_UNDEF = 2'h2,
      BPCM_SZ_DWORD = 2'h3
   } bpcm_size_e;
   typedef enum logic [1:0] {
      BPCM_AT_EXEC  = 2'h0,
      BPCM_AT_WRITE = 2'h1,
      BPCM_AT_UNDEF = 2'h2,
      BPCM_AT_RDWR  = 2'h3
   } bpcm_access_e;
endpackage

// File: bench/bpcm_chk.sv
// port assertions for the breakpoint block
module bpcm_chk (
   input wire logic        mclk, srst, psel, penable, pready, pslverr,
   input wire logic [31:0] prdata,
   input wire logic        instrStart, dataValid, dataDone, dbgRegAccess, protMode,
   input wire logic [1:0]  privLevel,
   input wire logic        faultExc1, trapExc1, privViolation, exactWait
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   sequence s_acc;
      psel && penable;
   endsequence
   a_apb_ready: assert property (s_acc |-> pready)
      else $error("access phase without ready");
   a_prdata_idle: assert property (!(psel && penable) |-> prdata == 32'h0)
      else $error("read data outside access");
   a_err_phase: assert property (pslverr |-> s_acc)
      else $error("error outside access");
   a_reset_quiet: assert property ($past(srst) |-> !faultExc1 && !trapExc1)
      else $error("exception right after reset");
   a_fault_cause: assert property (faultExc1 |-> instrStart || dbgRegAccess)
      else $error("fault without cause");
   a_trap_cause: assert property (trapExc1 |-> dataDone || instrStart)
      else $error("trap without completion");
   a_wait_cause: assert property (exactWait |-> dataValid)
      else $error("wait without data access");
   a_priv_flag: assert property (privViolation == (dbgRegAccess && protMode && privLevel != 2'h0))
      else $error("privilege flag wrong");
endmodule
bind bpcm_breakpoint_control_match bpcm_chk u_chk (.mclk, .srst, .psel, .penable, .pready,
   .pslverr, .prdata, .instrStart, .dataValid, .dataDone, .dbgRegAccess, .protMode,
   .privLevel, .faultExc1, .trapExc1, .privViolation, .exactWait);

// File: bench/bpcm_core_model.sv
// behavioural execution core facing the breakpoint block
module bpcm_core_model (
   input wire logic    mclk, faultExc1, trapExc1, exactWait, privViolation,
   output logic        instrStart, dataValid, dataWrite, dataDone, taskSwitch,
   output logic        handlerEntry, dbgRegAccess, protMode,
   output logic [31:0] instrAddr, dataAddr,
   output logic [1:0]  dataBytesMinus1, privLevel
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      {dataDone, handlerEntry, taskSwitch, dbgRegAccess, dataWrite, dataValid, instrStart} = '0;
      {protMode, privLevel, dataBytesMinus1} = '0;
      instrAddr = '0;
      dataAddr = '0;
   end
   // one event, then an idle cycle so no pulse is raised twice in one time step
   task automatic step(input logic [6:0] p, input logic [31:0] a, input logic [1:0] n,
                       input logic [2:0] m, output logic [3:0] r);
      {dataDone, handlerEntry, taskSwitch, dbgRegAccess, dataWrite, dataValid, instrStart} <= p;
      {protMode, privLevel} <= m;
      instrAddr <= a;
      dataAddr <= a;
      dataBytesMinus1 <= n;
      @(posedge mclk);
      r = {faultExc1, trapExc1, exactWait, privViolation};
      {dataDone, handlerEntry, taskSwitch, dbgRegAccess, dataWrite, dataValid, instrStart} <= '0;
      // released address must not keep its last value
      instrAddr <= ~a;
      dataAddr <= ~a;
      @(posedge mclk);
   endtask
endmodule

// File: bench/tb.sv
// self-checking bench for the breakpoint block
`include "bpcm_consts.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, instrAddr, dataAddr;
   logic        pready, pslverr, instrStart, dataValid, dataWrite, dataDone, taskSwitch;
   logic        handlerEntry, dbgRegAccess, protMode, faultExc1, trapExc1, privViolation;
   logic        exactWait;
   logic [1:0]  dataBytesMinus1, privLevel;
   logic [3:0]  r;
   int          mismatches = 0, checked = 0;
   always #50 mclk = ~mclk;
   bpcm_breakpoint_control_match u_dut (.mclk, .srst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .instrStart, .instrAddr, .dataValid, .dataWrite,
      .dataAddr, .dataBytesMinus1, .dataDone, .taskSwitch, .handlerEntry, .dbgRegAccess,
      .protMode, .privLevel, .faultExc1, .trapExc1, .privViolation, .exactWait);
   bpcm_core_model u_core (.mclk, .faultExc1, .trapExc1, .exactWait, .privViolation,
      .instrStart, .dataValid, .dataWrite, .dataDone, .taskSwitch, .handlerEntry,
      .dbgRegAccess, .protMode, .instrAddr, .dataAddr, .dataBytesMinus1, .privLevel);
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   // e holds the expected error flag above the expected read data
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic [32:0] e);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1;
      do @(posedge mclk); while (pready !== 1'b1);
      if (!w) chk("prdata", e[31:0], prdata);
      chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
      psel <= 0;
      penable <= 0;
      @(posedge mclk);
   endtask
   task automatic ev(logic [6:0] p, logic [31:0] a, logic [1:0] n, logic [2:0] m, logic [3:0] e);
      u_core.step(p, a, n, m, r);
      chk("core", {28'h0, e}, {28'h0, r});
   endtask
   task results;
      if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #100000 mismatches++;
      results();
   end
   initial begin
      repeat (8) @(posedge mclk);
      srst <= 0;
      apb(0, `BPCM_ADDR_CONTROL, 0, 0);
      apb(0, 12'hffc, 0, 33'h1_0000_0000);
      apb(1, `BPCM_ADDR_SLOT0, 32'h100, 0);
      apb(1, `BPCM_ADDR_CONTROL, 32'h2, 0);
      ev(7'h01, 32'h100, 0, 0, 4'h8);
      ev(7'h01, 32'h101, 0, 0, 4'h0);
      apb(0, `BPCM_ADDR_STATUS, 0, 33'h1);
      apb(1, `BPCM_ADDR_STATUS, 0, 0);
      apb(1, `BPCM_ADDR_SLOT1, 32'h206, 0);
      apb(1, `BPCM_ADDR_CONTROL, 32'h00d0_030c, 0);
      ev(7'h06, 32'h202, 3, 0, 4'h2);
      ev(7'h40, 32'h0, 0, 0, 4'h4);
      ev(7'h02, 32'h207, 0, 0, 4'h2);
      ev(7'h40, 32'h0, 0, 0, 4'h0);
      apb(0, `BPCM_ADDR_STATUS, 0, 33'h2);
      ev(7'h10, 32'h0, 0, 0, 4'h0);
      apb(0, `BPCM_ADDR_CONTROL, 0, 33'h00d0_0208);
      apb(1, `BPCM_ADDR_CONTROL, 32'h2000, 0);
      ev(7'h08, 32'h0, 0, 0, 4'h8);
      apb(0, `BPCM_ADDR_STATUS, 0, 33'h2002);
      ev(7'h20, 32'h0, 0, 0, 4'h0);
      apb(0, `BPCM_ADDR_CONTROL, 0, 0);
      ev(7'h08, 32'h0, 0, 3'h7, 4'h1);
      apb(1, `BPCM_ADDR_CONTROL, 32'h00d0_0008, 0);
      ev(7'h06, 32'h204, 0, 0, 4'h0);
      ev(7'h40, 32'h0, 0, 0, 4'h0);
      ev(7'h01, 32'h300, 0, 0, 4'h4);
      results();
   end
endmodule
